/* sli_indicator_top.sv */
// Purpose: Drives the registration, activity, status and ring indicators.
// Assumes: State inputs come from logic on core_clk; urcNew is a pulse.
// Notes: Open-drain status uses an active-low output enable.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// [RULE1] Registration output high only while registered on LTE, else low.
// [RULE2] Searching: activity output 200 ms high, 1800 ms low, repeating.
// [RULE3] Idle: activity output 1800 ms high, 200 ms low, repeating.
// [RULE4] Data transfer: activity output 125 ms high, 125 ms low.
// [RULE5] Voice call holds activity output high and overrides blinking.
// [RULE6] Status pin driven low once powered on normally, else released.
// [RULE7] Board must pull the status pin up so release reads high.
// [RULE8] Ring output rests at its idle level, high by default.
// [RULE9] Each new notification gives one 120 ms low ring pulse; the code pulses to the inverse of ringIdleLevel, so high when that is low.
// [RULE10] Every notification triggers the pulse, whatever its port.
// [RULE11] Ring idle level and pulse enable are configurable settings.
module sli_indicator_top #(
   parameter int unsigned MS_DIV = sli_pkg::CYCLES_PER_MS
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Network state from the modem core
   input wire logic regOnLte,
   input wire logic searching,
   input wire logic idleOnNet,
   input wire logic dataActive,
   input wire logic voiceCall,
   input wire logic poweredOn,
   // Notifications, one pulse bit per host port
   input wire logic [2:0] urcNew,
   // Ring configuration
   input wire logic ringPulseEn,
   input wire logic ringIdleLevel,
   // Indicator outputs
   output logic net_registration_indicator,
   output logic net_activity_indicator,
   output logic statusOut,
   output logic statusOe_n,
   output logic ring_indicator_out
);
   sli_tick_if tickBus();
   sli_ms_timebase #(.DIV(MS_DIV)) uTimebase (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .tick(tickBus)
   );
   wire logic msTick = tickBus.msTick;

   // Picks the activity mode; voice has the highest priority.
   function automatic sli_pkg::sli_act_e pickMode(input logic v,
         input logic d, input logic i, input logic s);
      if (v) begin
         return sli_pkg::SLI_ACT_VOICE;
      end else if (d) begin
         return sli_pkg::SLI_ACT_DATA;
      end else if (i) begin
         return sli_pkg::SLI_ACT_IDLE;
      end else if (s) begin
         return sli_pkg::SLI_ACT_SEARCH;
      end
      return sli_pkg::SLI_ACT_OFF;
   endfunction

   sli_pkg::sli_act_e mode_reg, mode_next;
   logic [11:0] phaseCnt_reg;
   logic phaseHigh_reg;
   logic [11:0] highLen, lowLen;
   logic reg_reg, act_reg, ring_reg;
   logic [11:0] ringCnt_reg;
   logic ringBusy_reg;

   assign mode_next = pickMode(voiceCall, dataActive, idleOnNet, searching);

   always_comb begin
      case (mode_reg)
         sli_pkg::SLI_ACT_SEARCH: begin
            highLen = 12'(sli_pkg::SEARCH_HIGH_MS); // [RULE2]
            lowLen = 12'(sli_pkg::SEARCH_LOW_MS);
         end
         sli_pkg::SLI_ACT_IDLE: begin
            highLen = 12'(sli_pkg::IDLE_HIGH_MS); // [RULE3]
            lowLen = 12'(sli_pkg::IDLE_LOW_MS);
         end
         sli_pkg::SLI_ACT_DATA: begin
            highLen = 12'(sli_pkg::DATA_HIGH_MS); // [RULE4]
            lowLen = 12'(sli_pkg::DATA_LOW_MS);
         end
         default: begin
            highLen = 12'h1;
            lowLen = 12'h1;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         reg_reg <= 1'b0;
      end else begin
         reg_reg <= regOnLte; // [RULE1]
      end
   end

   // A mode change restarts the pattern at the start of its high phase.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         mode_reg <= sli_pkg::SLI_ACT_OFF;
         phaseCnt_reg <= 12'h0;
         phaseHigh_reg <= 1'b1;
      end else if (mode_next != mode_reg) begin
         mode_reg <= mode_next;
         phaseCnt_reg <= 12'h0;
         phaseHigh_reg <= 1'b1;
      end else if (msTick) begin
         if (phaseCnt_reg == (phaseHigh_reg ? highLen : lowLen) - 12'h1)
            begin
            phaseCnt_reg <= 12'h0;
            phaseHigh_reg <= !phaseHigh_reg;
         end else begin
            phaseCnt_reg <= phaseCnt_reg + 12'h1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         act_reg <= 1'b0;
      end else begin
         case (mode_reg)
            sli_pkg::SLI_ACT_VOICE: act_reg <= 1'b1; // [RULE5]
            sli_pkg::SLI_ACT_SEARCH,
            sli_pkg::SLI_ACT_IDLE,
            sli_pkg::SLI_ACT_DATA: act_reg <= phaseHigh_reg; // [RULE2]
            default: act_reg <= 1'b0;
         endcase
      end
   end

   // A notification during a pulse restarts it, so none is swallowed.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ringBusy_reg <= 1'b0;
         ringCnt_reg <= 12'h0;
      end else if ((|urcNew) && ringPulseEn) begin // [RULE10]
         ringBusy_reg <= 1'b1; // [RULE9]
         ringCnt_reg <= 12'h0;
      end else if (ringBusy_reg && msTick) begin
         if (ringCnt_reg == 12'(sli_pkg::RING_PULSE_MS - 1)) begin
            ringBusy_reg <= 1'b0;
         end else begin
            ringCnt_reg <= ringCnt_reg + 12'h1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ring_reg <= sli_pkg::RING_IDLE_LEVEL_RST;
      end else begin
         ring_reg <= ringIdleLevel ^ ringBusy_reg; // [RULE8] [RULE11]
      end
   end

   // The pad releases to the external pull-up when not on.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         statusOe_n <= 1'b1;
      end else begin
         statusOe_n <= !poweredOn; // [RULE6] [RULE7]
      end
   end

   assign statusOut = 1'b0;
   assign net_registration_indicator = reg_reg;
   assign net_activity_indicator = act_reg;
   assign ring_indicator_out = ring_reg;

   property pRegFollow;
      @(posedge core_clk) disable iff (!rst_n)
         regOnLte |=> net_registration_indicator;
   endproperty
   chk_reg_follows: assert property (pRegFollow) // [RULE1]
      else $error("registration output not high while on LTE");

   // The mode register takes one edge and the output flop another.
   chk_voice_steady: assert property (@(posedge core_clk) // [RULE5]
      disable iff (!rst_n)
      voiceCall |=> ##1 net_activity_indicator)
      else $error("activity output not steady in voice call");

   chk_status_drive: assert property (@(posedge core_clk) // [RULE6]
      disable iff (!rst_n)
      poweredOn |=> !statusOe_n)
      else $error("status pin not driven when powered on");

   sequence sUrc;
      (|urcNew) && ringPulseEn;
   endsequence
   chk_ring_start: assert property (@(posedge core_clk) // [RULE9]
      disable iff (!rst_n)
      sUrc |=> ##1 (ring_indicator_out == !$past(ringIdleLevel)))
      else $error("ring pulse did not start");

   chk_ring_idle: assert property (@(posedge core_clk) // [RULE8]
      disable iff (!rst_n)
      (!ringBusy_reg && $stable(ringIdleLevel)) |=>
         ring_indicator_out == $past(ringIdleLevel))
      else $error("ring output left idle level");

   chk_search_high: assert property (@(posedge core_clk) // [RULE2]
      disable iff (!rst_n)
      (mode_reg == sli_pkg::SLI_ACT_SEARCH && phaseHigh_reg)
         |-> phaseCnt_reg < 12'(sli_pkg::SEARCH_HIGH_MS))
      else $error("search high phase too long");

   chk_idle_low: assert property (@(posedge core_clk) // [RULE3]
      disable iff (!rst_n)
      (mode_reg == sli_pkg::SLI_ACT_IDLE && !phaseHigh_reg)
         |-> phaseCnt_reg < 12'(sli_pkg::IDLE_LOW_MS))
      else $error("idle low phase too long");

   chk_data_phase: assert property (@(posedge core_clk) // [RULE4]
      disable iff (!rst_n)
      (mode_reg == sli_pkg::SLI_ACT_DATA)
         |-> phaseCnt_reg < 12'(sli_pkg::DATA_HIGH_MS))
      else $error("data phase too long");

   chk_any_port: assert property (@(posedge core_clk) // [RULE10]
      disable iff (!rst_n)
      (ringPulseEn && urcNew != 3'h0) |=> ringBusy_reg)
      else $error("notification on a port missed");
endmodule
`default_nettype wire

/* sli_pkg.sv */
// Purpose: Shared constants and types for the status and ring indicators.
// Assumes: 250 MHz core clock and a 1 ms enable tick.
// Notes: Durations are in milliseconds; cycle counts derive from them.
`default_nettype none
package sli_pkg;
   localparam int unsigned CLK_HZ = 250000000;
   localparam int unsigned MS_PERIOD_NS = 1000000;
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned CYCLES_PER_MS = MS_PERIOD_NS / CLK_PERIOD_NS;
   localparam int unsigned SEARCH_HIGH_MS = 200;
   localparam int unsigned SEARCH_LOW_MS = 1800;
   localparam int unsigned IDLE_HIGH_MS = 1800;
   localparam int unsigned IDLE_LOW_MS = 200;
   localparam int unsigned DATA_HIGH_MS = 125;
   localparam int unsigned DATA_LOW_MS = 125;
   localparam int unsigned RING_PULSE_MS = 120;
   localparam int unsigned MS_CNT_W = 12;
   localparam logic RING_IDLE_LEVEL_RST = 1'b1;
   typedef enum logic [2:0] {
      SLI_ACT_OFF,
      SLI_ACT_SEARCH,
      SLI_ACT_IDLE,
      SLI_ACT_DATA,
      SLI_ACT_VOICE
   } sli_act_e;
endpackage
`default_nettype wire

/* sli_tick_if.sv */
// Purpose: Carries the millisecond tick between indicator modules.
// Assumes: One clock domain.
// Notes: The tick is a one-cycle enable.
`timescale 1ns/10ps
`default_nettype none
interface sli_tick_if;
   logic msTick;
   modport source (output msTick);
   modport sink (input msTick);
endinterface
`default_nettype wire

/* sli_ms_timebase.sv */
// Purpose: Divides the core clock into a one-cycle millisecond enable.
// Assumes: core_clk at 250 MHz.
// Notes: Free running after reset.
`timescale 1ns/10ps
`default_nettype none
module sli_ms_timebase #(
   parameter int unsigned DIV = sli_pkg::CYCLES_PER_MS
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Tick out
   sli_tick_if.source tick
);
   logic [19:0] divCnt_reg;
   always_ff @(posedge core_clk) begin
      if (!rst_n || divCnt_reg == 20'(DIV - 1)) begin
         divCnt_reg <= 20'h0;
      end else begin
         divCnt_reg <= divCnt_reg + 20'h1;
      end
   end
   assign tick.msTick = rst_n && (divCnt_reg == 20'(DIV - 1));
endmodule
`default_nettype wire

/* sli_host_side.sv */
// Purpose: Host-side model of the open-drain status pin.
// Assumes: The board fits a pull-up on the status pin.
// Notes: A released pin reads high, never as the last driven value.
`timescale 1ns/10ps
`default_nettype none
module sli_host_side (
   // Status pin from the device
   input wire logic statusOut,
   input wire logic statusOe_n,
   // Level the host GPIO sees
   output logic statusPin
);
   assign statusPin = statusOe_n ? 1'h1 : statusOut;
endmodule
`default_nettype wire

/* test_status_led_and_ring_indicator.sv */
// Purpose: Self-checking bench for the status and ring indicators.
// Assumes: MS_DIV of 4, so one millisecond is four clock cycles.
// Notes: Outputs are sampled on the falling edge to avoid races.
`timescale 1ns/10ps
`default_nettype none
module test_status_led_and_ring_indicator;
   localparam int unsigned DIV = 4;
   logic core_clk = 1'h0;
   logic rst_n = 1'h0;
   logic regOnLte = 1'h0;
   logic searching = 1'h0;
   logic idleOnNet = 1'h0;
   logic dataActive = 1'h0;
   logic voiceCall = 1'h0;
   logic poweredOn = 1'h0;
   logic [2:0] urcNew = 3'h0;
   logic ringPulseEn = 1'h1;
   logic ringIdleLevel = 1'h1;
   logic regInd, actInd, statusOut, statusOe_n, ringOut, statusPin;
   int errors = 0;
   int checks = 0;
   int cycles = 0;
   always #2 core_clk = ~core_clk;
   sli_indicator_top #(.MS_DIV(DIV)) i_dut (
      .core_clk(core_clk), .rst_n(rst_n), .regOnLte(regOnLte),
      .searching(searching), .idleOnNet(idleOnNet),
      .dataActive(dataActive), .voiceCall(voiceCall),
      .poweredOn(poweredOn), .urcNew(urcNew), .ringPulseEn(ringPulseEn),
      .ringIdleLevel(ringIdleLevel), .net_registration_indicator(regInd),
      .net_activity_indicator(actInd), .statusOut(statusOut),
      .statusOe_n(statusOe_n), .ring_indicator_out(ringOut));
   sli_host_side i_host (.statusOut(statusOut), .statusOe_n(statusOe_n),
      .statusPin(statusPin));
   task automatic check(input string what, input logic [31:0] seen,
         input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // The whole run needs about 30000 cycles; twice that means a hang.
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         errors++;
         final_report();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // Waits for a phase at level lvl to start, then returns its length.
   task automatic run_len(input logic lvl, output int n);
      n = 0;
      while (actInd !== lvl) @(negedge core_clk);
      while (actInd === lvl) begin
         n++;
         @(negedge core_clk);
      end
   endtask
   task automatic test_reset();
      check("reg idle", regInd, 1'h0);
      check("act idle", actInd, 1'h0);
      check("status released", statusPin, 1'h1);
      check("ring idle", ringOut, 1'h1);
      $display("test reset done");
   endtask
   task automatic test_levels();
      @(posedge core_clk);
      regOnLte <= 1'h1;
      poweredOn <= 1'h1;
      tick(3);
      check("reg on", regInd, 1'h1);
      check("status low", statusPin, 1'h0);
      @(posedge core_clk);
      regOnLte <= 1'h0;
      poweredOn <= 1'h0;
      tick(3);
      check("reg off", regInd, 1'h0);
      check("status off", statusPin, 1'h1);
      $display("test levels done");
   endtask
   task automatic test_blink();
      int unsigned hiMs[3] = '{sli_pkg::SEARCH_HIGH_MS,
         sli_pkg::IDLE_HIGH_MS, sli_pkg::DATA_HIGH_MS};
      int unsigned loMs[3] = '{sli_pkg::SEARCH_LOW_MS,
         sli_pkg::IDLE_LOW_MS, sli_pkg::DATA_LOW_MS};
      int hi;
      int lo;
      for (int k = 0; k < 3; k++) begin
         @(posedge core_clk);
         {dataActive, idleOnNet, searching} <= 3'h1 << k;
         tick(4);
         run_len(1'h0, lo);
         run_len(1'h1, hi);
         check("blink low", lo, loMs[k] * DIV);
         check("blink high", hi, hiMs[k] * DIV);
      end
      @(posedge core_clk);
      voiceCall <= 1'h1;
      tick(4);
      lo = 0;
      repeat (600) begin
         @(negedge core_clk);
         lo += (actInd !== 1'h1);
      end
      check("voice steady", lo, 0);
      @(posedge core_clk);
      {voiceCall, dataActive} <= 2'h0;
      $display("test blink done");
   endtask
   task automatic pulse_urc(input logic [2:0] v);
      @(posedge core_clk);
      urcNew <= v;
      @(posedge core_clk);
      urcNew <= 3'h0;
      tick(3);
   endtask
   task automatic test_ring();
      int n;
      for (int p = 0; p < 3; p++) begin
         pulse_urc(3'h1 << p);
         n = 0;
         while (ringOut === 1'h0) begin
            n++;
            @(negedge core_clk);
         end
         // The first low sample was taken inside pulse_urc, hence n + 1.
         check("ring pulse", 32'(n + 1 > (sli_pkg::RING_PULSE_MS - 1) * DIV
            && n + 1 <= sli_pkg::RING_PULSE_MS * DIV), 1);
         check("ring back", ringOut, 1'h1);
      end
      @(posedge core_clk);
      ringPulseEn <= 1'h0;
      pulse_urc(3'h7);
      check("ring masked", ringOut, 1'h1);
      @(posedge core_clk);
      ringIdleLevel <= 1'h0;
      tick(3);
      check("ring idle low", ringOut, 1'h0);
      @(posedge core_clk);
      {ringPulseEn, ringIdleLevel} <= 2'h3;
      $display("test ring done");
   endtask
   initial begin
      repeat (10) @(posedge core_clk);
      rst_n <= 1'h1;
      tick(2);
      test_reset();
      test_levels();
      test_blink();
      test_ring();
      final_report();
   end
endmodule
`default_nettype wire
